// file: src/fwp_top.sv
// Flash write protection: command gating, status protection and latch
//
// Behaviour
// RULE_01: Complement bit at S14, resets to zero.
// RULE_02: Two-bit drive field sets output strength.
// RULE_03: Mode 00 allows status write with latch.
// RULE_04: Mode 01 with pin low locks status.
// RULE_05: Mode 01 with pin high allows write.
// RULE_06: Mode 10 locks until power cycle.
// RULE_07: Mode 11 writes are rejected, mode kept.
// RULE_08: Deep power-down ignores all but release.
// RULE_09: Write-enable command sets the latch.
// RULE_10: Listed commands and power-up clear latch.
// RULE_11: Low codes protect top fractions of array.
// RULE_12: Upper bits 01 protect bottom fractions.
// RULE_13: Code 000 none, 111 whole array.
// RULE_14: Upper bits 10 protect small top blocks.
// RULE_15: Upper bits 11 protect small bottom blocks.
// RULE_16: Complement bit inverts the protected region.
// RULE_17: Protected region stays readable.
// RULE_18: Compare full address and extent first.
// RULE_19: No program or erase inside protection.
// RULE_20: Clear latch refuses writes, programs, erases.
// RULE_21: Chip erase only with empty protection.
// RULE_22: Mode bits at S8, S7; protect at S6-S2.
//
// Our own choices: the register addresses and the address-and-strobe port.
module fwp_top
	import fwp_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// Serial link pins
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_sck_i,
	input  wire logic        spi_si_i,
	input  wire logic        wp_n_i,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Device state
	output logic             write_enable_latch_o,
	output logic             deep_power_down_o,
	output logic      [1:0]  drive_strength_o,
	// Program and erase launch
	output logic             op_start_o,
	output fwp_op_e          op_kind_o,
	output logic      [23:0] op_addr_o,
	output logic             op_reject_o
);

	// ********************************
	// Pin synchronisers
	// ********************************
	logic [2:0] sck_sync_reg;
	logic [2:0] cs_sync_reg;
	logic [1:0] si_sync_reg;
	logic [1:0] wp_sync_reg;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			sck_sync_reg <= 3'h0;
			cs_sync_reg  <= 3'h7;
			si_sync_reg  <= 2'h0;
			wp_sync_reg  <= 2'h0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], spi_sck_i};
			cs_sync_reg  <= {cs_sync_reg[1:0], spi_cs_n_i};
			si_sync_reg  <= {si_sync_reg[0], spi_si_i};
			wp_sync_reg  <= {wp_sync_reg[0], wp_n_i};
		end
	end

	// Edges are taken between the second and third stages only
	wire sck_rise_w = sck_sync_reg[1] & ~sck_sync_reg[2];
	wire cs_rise_w  = cs_sync_reg[1] & ~cs_sync_reg[2];
	wire cs_fall_w  = ~cs_sync_reg[1] & cs_sync_reg[2];
	wire selected_w = ~cs_sync_reg[1];
	wire wp_high_w  = wp_sync_reg[1];

	// ********************************
	// Command shifter
	// ********************************
	logic [7:0]  shift_reg;
	logic [2:0]  bit_cnt_reg;
	logic [2:0]  byte_cnt_reg;
	logic [7:0]  cmd_reg;
	logic [23:0] addr_reg;
	logic [7:0]  data_reg;

	wire       shift_en_w  = sck_rise_w & selected_w;
	wire [7:0] shift_next  = {shift_reg[6:0], si_sync_reg[1]};
	wire       byte_end_w  = shift_en_w & (bit_cnt_reg == BIT_LAST);
	wire       byte_sat_w  = byte_cnt_reg == BYTES_PP;
	wire [2:0] byte_cnt_next = byte_sat_w ? byte_cnt_reg : (byte_cnt_reg + BYTE_ONE);
	wire       addr_byte_w = (byte_cnt_reg != BIT_ZERO) & (byte_cnt_reg < BYTES_ADDR);

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (cs_fall_w) begin
			bit_cnt_reg  <= BIT_ZERO;
			byte_cnt_reg <= BIT_ZERO;
		end else if (shift_en_w) begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_reg + BYTE_ONE;
			if (byte_end_w) begin
				byte_cnt_reg <= byte_cnt_next;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cmd_reg  <= 8'h00;
			addr_reg <= 24'h000000;
			data_reg <= 8'h00;
		end else if (byte_end_w) begin
			if (byte_cnt_reg == BIT_ZERO) begin
				cmd_reg <= shift_next;
			end
			if (byte_cnt_reg == BYTE_ONE) begin
				data_reg <= shift_next;
			end
			if (addr_byte_w) begin
				addr_reg <= {addr_reg[15:0], shift_next};
			end
		end
	end

	// ********************************
	// Command decode
	// ********************************
	logic       wel_reg;
	logic       dpd_reg;
	logic       rst_en_reg;
	logic [4:0] bp_reg;
	logic       status_lock_mode_lo_reg;
	logic       status_lock_mode_hi_reg;
	logic       cmp_reg;
	logic [1:0] drv_reg;

	// A command counts only if select rises on a byte boundary
	wire cmd_done_w = cs_rise_w & (bit_cnt_reg == BIT_ZERO) & (byte_cnt_reg != BIT_ZERO);
	wire gated_w    = dpd_reg & (cmd_reg != CMD_RDPD); // RULE_08
	wire act_w      = cmd_done_w & ~gated_w; // RULE_08

	wire is_wren_w  = cmd_reg == CMD_WREN;
	wire is_wrdi_w  = cmd_reg == CMD_WRDI;
	wire is_wrsr1_w = cmd_reg == CMD_WRSR1;
	wire is_wrsr2_w = cmd_reg == CMD_WRSR2;
	wire is_wrsr3_w = cmd_reg == CMD_WRSR3;
	wire is_wrsr_w  = is_wrsr1_w | is_wrsr2_w | is_wrsr3_w;
	wire is_pp_w    = (cmd_reg == CMD_PP) | (cmd_reg == CMD_QPP) | (cmd_reg == CMD_FPP);
	wire is_se_w    = cmd_reg == CMD_SE;
	wire is_be32_w  = cmd_reg == CMD_BE32;
	wire is_be64_w  = cmd_reg == CMD_BE64;
	wire is_ce_w    = (cmd_reg == CMD_CE1) | (cmd_reg == CMD_CE2);
	wire is_dpd_w   = cmd_reg == CMD_DPD;
	wire is_rdpd_w  = cmd_reg == CMD_RDPD;
	wire is_rsten_w = cmd_reg == CMD_RSTEN;
	wire soft_rst_w = (cmd_reg == CMD_RST) & rst_en_reg;
	// Only program and erase are gated; reads never look at the range
	wire is_mod_w   = is_pp_w | is_se_w | is_be32_w | is_be64_w; // RULE_17

	// ********************************
	// Status register protection
	// ********************************
	wire [1:0] srp_w        = {status_lock_mode_hi_reg, status_lock_mode_lo_reg};
	wire       sr_unlock_w  = (srp_w == SRP_SW) | ((srp_w == SRP_HW) & wp_high_w); // RULE_03 RULE_04 RULE_05 RULE_06
	wire [1:0] srp_new_w    = is_wrsr1_w ? {status_lock_mode_hi_reg, data_reg[B1_STATUS_LOCK_MODE_LO]}
	                        : is_wrsr2_w ? {data_reg[B2_STATUS_LOCK_MODE_HI], status_lock_mode_lo_reg} : srp_w;
	wire       srp_bad_w    = srp_new_w == SRP_BAD; // RULE_07
	wire       wrsr_len_w   = byte_cnt_reg == BYTES_WRSR;
	wire       wrsr_ok_w    = is_wrsr_w & wrsr_len_w & wel_reg & sr_unlock_w & ~srp_bad_w; // RULE_20

	// ********************************
	// Array protection
	// ********************************
	logic        prot_en_w;
	logic [23:0] prot_lo_w;
	logic [23:0] prot_hi_w;

	fwp_range_dec u_range_dec (
		.protect_complement_i (cmp_reg),
		.block_protect_i      (bp_reg),
		.prot_en_o            (prot_en_w),
		.prot_lo_o            (prot_lo_w),
		.prot_hi_o            (prot_hi_w)
	);

	// Whole page is checked since programming wraps inside it
	wire [23:0] op_mask_w = is_pp_w ? PAGE_MASK : is_se_w ? SECTOR_MASK
	                      : is_be32_w ? BLK32_MASK : BLK64_MASK;
	wire [23:0] op_lo_w   = addr_reg & ~op_mask_w; // RULE_18
	wire [23:0] op_hi_w   = addr_reg | op_mask_w; // RULE_18
	wire        overlap_w = prot_en_w & ~((op_hi_w < prot_lo_w) | (op_lo_w > prot_hi_w)); // RULE_19
	wire        mod_len_w = is_pp_w ? (byte_cnt_reg == BYTES_PP) : (byte_cnt_reg == BYTES_ADDR);
	wire        mod_ok_w  = is_mod_w & mod_len_w & wel_reg & ~overlap_w; // RULE_19 RULE_20
	wire        ce_free_w = ((bp_reg[2:0] == BP_NONE) & ~cmp_reg) | ((bp_reg[2:0] == BP_ALL) & cmp_reg);
	wire        ce_ok_w   = is_ce_w & (byte_cnt_reg == BYTE_ONE) & wel_reg & ce_free_w; // RULE_21
	wire        exec_ok_w = mod_ok_w | ce_ok_w;
	wire        writer_w  = is_wrsr_w | is_mod_w | is_ce_w;
	wire        reject_w  = act_w & writer_w & ~(wrsr_ok_w | exec_ok_w);
	wire fwp_op_e kind_w  = is_ce_w ? FWP_OP_CHIP : is_pp_w ? FWP_OP_PROG
	                      : is_se_w ? FWP_OP_SECTOR : is_be32_w ? FWP_OP_BLK32 : FWP_OP_BLK64;

	// ********************************
	// Latch and power state
	// ********************************
	wire wel_clr_w = act_w & (is_wrdi_w | wrsr_ok_w | exec_ok_w | soft_rst_w); // RULE_10

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			wel_reg    <= 1'b0; // RULE_10
			dpd_reg    <= 1'b0;
			rst_en_reg <= 1'b0;
		end else if (act_w) begin
			wel_reg    <= is_wren_w | (wel_reg & ~wel_clr_w); // RULE_09 RULE_10
			dpd_reg    <= is_dpd_w | (dpd_reg & ~is_rdpd_w); // RULE_08
			rst_en_reg <= is_rsten_w;
		end
	end

	// ********************************
	// Protection bits
	// ********************************
	// Factory image loaded from the register port; a mode of 11 is refused
	wire       nv_wr_w    = reg_wr_i & (reg_addr_i == REG_NV_IMAGE);
	wire [1:0] nv_srp_w   = {reg_wdata_i[ST_STATUS_LOCK_MODE_HI], reg_wdata_i[ST_STATUS_LOCK_MODE_LO]};
	wire       nv_ok_w    = nv_wr_w & (nv_srp_w != SRP_BAD); // RULE_07
	wire       sr_wr1_w   = act_w & wrsr_ok_w & is_wrsr1_w;
	wire       sr_wr2_w   = act_w & wrsr_ok_w & is_wrsr2_w;
	wire       sr_wr3_w   = act_w & wrsr_ok_w & is_wrsr3_w;

	// Power-on always drops the lock-down mode back to software mode
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			bp_reg   <= BP_RESET;
			status_lock_mode_lo_reg <= 1'b0; // RULE_06
			status_lock_mode_hi_reg <= 1'b0; // RULE_06
			cmp_reg  <= 1'b0; // RULE_01
			drv_reg  <= DRV_FULL; // RULE_02
		end else if (nv_ok_w) begin
			bp_reg   <= reg_wdata_i[ST_BP_HI:ST_BP_LO];
			status_lock_mode_lo_reg <= reg_wdata_i[ST_STATUS_LOCK_MODE_LO];
			status_lock_mode_hi_reg <= reg_wdata_i[ST_STATUS_LOCK_MODE_HI];
			cmp_reg  <= reg_wdata_i[ST_CMP];
			drv_reg  <= reg_wdata_i[ST_DRV_HI:ST_DRV_LO];
		end else if (sr_wr1_w) begin
			bp_reg   <= data_reg[B1_BP_HI:B1_BP_LO]; // RULE_22
			status_lock_mode_lo_reg <= data_reg[B1_STATUS_LOCK_MODE_LO]; // RULE_22
		end else if (sr_wr2_w) begin
			status_lock_mode_hi_reg <= data_reg[B2_STATUS_LOCK_MODE_HI]; // RULE_22
			cmp_reg  <= data_reg[B2_CMP]; // RULE_01
		end else if (sr_wr3_w) begin
			drv_reg  <= data_reg[B3_DRV_HI:B3_DRV_LO]; // RULE_02
		end
	end

	// ********************************
	// Launch outputs
	// ********************************
	logic    op_start_reg;
	logic    op_reject_reg;
	fwp_op_e op_kind_reg;
	logic [23:0] op_addr_reg;
	logic [7:0]  last_cmd_reg;
	logic        last_acc_reg;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			op_start_reg  <= 1'b0;
			op_reject_reg <= 1'b0;
			op_kind_reg   <= FWP_OP_PROG;
			op_addr_reg   <= 24'h000000;
		end else begin
			op_start_reg  <= act_w & exec_ok_w; // RULE_19 RULE_21
			op_reject_reg <= reject_w;
			if (act_w & exec_ok_w) begin
				op_kind_reg <= kind_w;
				op_addr_reg <= is_ce_w ? ADDR_ZERO : addr_reg;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			last_cmd_reg <= 8'h00;
			last_acc_reg <= 1'b0;
		end else if (act_w) begin
			last_cmd_reg <= cmd_reg;
			last_acc_reg <= ~reject_w;
		end
	end

	// ********************************
	// Register read port
	// ********************************
	wire [23:0] status_w = {1'b0, drv_reg, 6'h00, cmp_reg, 5'h00, status_lock_mode_hi_reg,
	                        status_lock_mode_lo_reg, bp_reg, wel_reg, 1'b0};
	wire [31:0] rd_mux_w = (reg_addr_i == REG_STATUS)   ? {8'h00, status_w}
	                     : (reg_addr_i == REG_NV_IMAGE) ? {8'h00, status_w}
	                     : (reg_addr_i == REG_PROT_LO)  ? {7'h00, prot_en_w, prot_lo_w}
	                     : (reg_addr_i == REG_PROT_HI)  ? {7'h00, prot_en_w, prot_hi_w}
	                     : (reg_addr_i == REG_LAST_OP)  ? {21'h000000, dpd_reg, op_reject_reg,
	                                                       last_acc_reg, last_cmd_reg}
	                     : 32'h00000000;
	logic [31:0] rdata_reg;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= reg_rd_i ? rd_mux_w : 32'h00000000;
		end
	end

	assign reg_rdata_o          = rdata_reg;
	assign write_enable_latch_o = wel_reg;
	assign deep_power_down_o    = dpd_reg;
	assign drive_strength_o     = drv_reg; // RULE_02
	assign op_start_o           = op_start_reg;
	assign op_kind_o            = op_kind_reg;
	assign op_addr_o            = op_addr_reg;
	assign op_reject_o          = op_reject_reg;

endmodule

// file: src/fwp_pkg.sv
// Constants and types shared by the flash write-protection logic
package fwp_pkg;

	// ********************************
	// Array and range decoding
	// ********************************
	localparam int          ADDR_W         = 24;
	localparam logic [23:0] ADDR_ZERO      = 24'h000000;
	localparam logic [23:0] ADDR_MAX       = 24'hffffff;
	localparam logic [23:0] ADDR_ONE       = 24'h000001;
	localparam logic [4:0]  FRAC_SH_BASE   = 5'h11;
	localparam logic [4:0]  SMALL_SH_BASE  = 5'h0b;
	localparam logic [2:0]  SMALL_CODE_MAX = 3'h4;
	localparam logic [2:0]  BP_NONE        = 3'h0;
	localparam logic [2:0]  BP_ALL         = 3'h7;

	// ********************************
	// Operation extents
	// ********************************
	localparam logic [23:0] PAGE_MASK   = 24'h0000ff;
	localparam logic [23:0] SECTOR_MASK = 24'h000fff;
	localparam logic [23:0] BLK32_MASK  = 24'h007fff;
	localparam logic [23:0] BLK64_MASK  = 24'h00ffff;

	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] CMD_WREN  = 8'h06;
	localparam logic [7:0] CMD_WRDI  = 8'h04;
	localparam logic [7:0] CMD_WRSR1 = 8'h01;
	localparam logic [7:0] CMD_WRSR2 = 8'h31;
	localparam logic [7:0] CMD_WRSR3 = 8'h11;
	localparam logic [7:0] CMD_PP    = 8'h02;
	localparam logic [7:0] CMD_QPP   = 8'h32;
	localparam logic [7:0] CMD_FPP   = 8'hf2;
	localparam logic [7:0] CMD_SE    = 8'h20;
	localparam logic [7:0] CMD_BE32  = 8'h52;
	localparam logic [7:0] CMD_BE64  = 8'hd8;
	localparam logic [7:0] CMD_CE1   = 8'hc7;
	localparam logic [7:0] CMD_CE2   = 8'h60;
	localparam logic [7:0] CMD_DPD   = 8'hb9;
	localparam logic [7:0] CMD_RDPD  = 8'hab;
	localparam logic [7:0] CMD_RSTEN = 8'h66;
	localparam logic [7:0] CMD_RST   = 8'h99;

	// ********************************
	// Serial framing
	// ********************************
	localparam logic [2:0] BIT_ZERO     = 3'h0;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [2:0] BYTE_ONE     = 3'h1;
	localparam logic [2:0] BYTES_WRSR   = 3'h2;
	localparam logic [2:0] BYTES_ADDR   = 3'h4;
	localparam logic [2:0] BYTES_PP     = 3'h5;

	// ********************************
	// Status bit fields
	// ********************************
	localparam int B1_STATUS_LOCK_MODE_LO = 7;
	localparam int B1_BP_HI = 6;
	localparam int B1_BP_LO = 2;
	localparam int B2_STATUS_LOCK_MODE_HI = 0;
	localparam int B2_CMP  = 6;
	localparam int B3_DRV_HI = 6;
	localparam int B3_DRV_LO = 5;
	localparam int ST_BP_HI = 6;
	localparam int ST_BP_LO = 2;
	localparam int ST_STATUS_LOCK_MODE_LO  = 7;
	localparam int ST_STATUS_LOCK_MODE_HI  = 8;
	localparam int ST_CMP   = 14;
	localparam int ST_DRV_HI = 22;
	localparam int ST_DRV_LO = 21;
	localparam logic [1:0] SRP_SW   = 2'h0;
	localparam logic [1:0] SRP_HW   = 2'h1;
	localparam logic [1:0] SRP_BAD  = 2'h3;
	localparam logic [1:0] DRV_FULL = 2'h0;
	localparam logic [4:0] BP_RESET = 5'h00;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_NV_IMAGE = 8'h04;
	localparam logic [7:0] REG_PROT_LO  = 8'h08;
	localparam logic [7:0] REG_PROT_HI  = 8'h0c;
	localparam logic [7:0] REG_LAST_OP  = 8'h10;

	typedef enum logic [2:0] {
		FWP_OP_PROG,
		FWP_OP_SECTOR,
		FWP_OP_BLK32,
		FWP_OP_BLK64,
		FWP_OP_CHIP
	} fwp_op_e;

endpackage

// file: src/fwp_range_dec.sv
// Protected address range decoder for the block-protect field
module fwp_range_dec
	import fwp_pkg::*;
(
	// Protection fields
	input  wire logic       protect_complement_i,
	input  wire logic [4:0] block_protect_i,
	// Decoded range
	output logic            prot_en_o,
	output logic [23:0]     prot_lo_o,
	output logic [23:0]     prot_hi_o
);

	// ********************************
	// Base region with complement clear
	// ********************************
	wire [2:0]  code_w       = block_protect_i[2:0];
	wire        small_w      = block_protect_i[4];
	wire        bottom_w     = block_protect_i[3];
	wire        none_code_w  = code_w == BP_NONE;
	wire        all_code_w   = code_w == BP_ALL;
	// Codes five and six give the 32 kB step; code seven still covers the whole array
	wire [2:0]  small_code_w = (code_w > SMALL_CODE_MAX) ? SMALL_CODE_MAX : code_w;
	wire [4:0]  shift_w      = small_w ? (SMALL_SH_BASE + {2'h0, small_code_w})
	                                   : (FRAC_SH_BASE + {2'h0, code_w});
	wire [23:0] size_w       = ADDR_ONE << shift_w;
	wire [23:0] span_w       = size_w - ADDR_ONE;
	wire [23:0] base_lo_w    = (all_code_w | bottom_w) ? ADDR_ZERO : (ADDR_MAX - span_w); // RULE_11 RULE_14
	wire [23:0] base_hi_w    = (all_code_w | ~bottom_w) ? ADDR_MAX : span_w; // RULE_12 RULE_15

	// ********************************
	// Complement selects the other side
	// ********************************
	assign prot_en_o = protect_complement_i ? ~all_code_w : ~none_code_w; // RULE_13 RULE_16
	assign prot_lo_o = ~protect_complement_i ? base_lo_w
	                 : (none_code_w | ~bottom_w) ? ADDR_ZERO : (span_w + ADDR_ONE); // RULE_16
	assign prot_hi_o = ~protect_complement_i ? base_hi_w
	                 : (none_code_w | bottom_w) ? ADDR_MAX : (base_lo_w - ADDR_ONE); // RULE_16

endmodule

// file: tb/fwp_checker.sv
// Concurrent checks on the protection block outputs
module fwp_checker
	import fwp_pkg::*;
(
	// Clock and reset
	input wire logic        mclk_i,
	input wire logic        reset_i,
	// Register strobe
	input wire logic        reg_wr_i,
	// Device outputs
	input wire logic        write_enable_latch_o,
	input wire logic        deep_power_down_o,
	input wire logic        op_start_o,
	input wire fwp_op_e     op_kind_o,
	input wire logic [23:0] op_addr_o,
	input wire logic        op_reject_o
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// ********************************
	// Properties
	// ********************************
	property p_start_needs_latch;
		op_start_o |-> $past(write_enable_latch_o);
	endproperty
	a_start_needs_latch: assert property (p_start_needs_latch)
		else $error("launch without write enable");

	property p_start_clears;
		op_start_o |-> !write_enable_latch_o ##1 !op_start_o;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("latch kept after launch");

	property p_start_or_reject;
		!(op_start_o && op_reject_o);
	endproperty
	a_start_or_reject: assert property (p_start_or_reject)
		else $error("launch and refusal together");

	// Cycles right after any register port write are excused from the check
	sequence s_asleep;
		deep_power_down_o && $past(deep_power_down_o) && !$past(reg_wr_i);
	endsequence
	property p_sleep_quiet;
		s_asleep |-> !op_start_o && !op_reject_o && $stable(write_enable_latch_o);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity during deep power-down");

	property p_reject_keeps;
		op_reject_o && !$past(reg_wr_i) |-> $stable(write_enable_latch_o) ##1 !op_reject_o;
	endproperty
	a_reject_keeps: assert property (p_reject_keeps)
		else $error("refusal changed latch");

	property p_latch_rise;
		$rose(write_enable_latch_o) |-> !deep_power_down_o && !op_start_o;
	endproperty
	a_latch_rise: assert property (p_latch_rise)
		else $error("latch set by wrong cause");

	property p_op_held;
		!op_start_o |-> $stable(op_kind_o) && $stable(op_addr_o);
	endproperty
	a_op_held: assert property (p_op_held)
		else $error("launch record changed");

	property p_chip_addr;
		op_start_o && op_kind_o == FWP_OP_CHIP |-> op_addr_o == 24'h000000;
	endproperty
	a_chip_addr: assert property (p_chip_addr)
		else $error("chip erase address not zero");

	c_chip: cover property (op_start_o && op_kind_o == FWP_OP_CHIP);
	c_reject: cover property (op_reject_o);
	c_sleep: cover property ($rose(deep_power_down_o));
endmodule

bind fwp_top fwp_checker u_chk (
	.mclk_i               (mclk_i),
	.reset_i              (reset_i),
	.reg_wr_i             (reg_wr_i),
	.write_enable_latch_o (write_enable_latch_o),
	.deep_power_down_o    (deep_power_down_o),
	.op_start_o           (op_start_o),
	.op_kind_o            (op_kind_o),
	.op_addr_o            (op_addr_o),
	.op_reject_o          (op_reject_o)
);

// file: tb/fwp_spi_host.sv
// Serial host model that frames commands toward the block
module fwp_spi_host (
	// Serial pins
	output logic spi_cs_n_o,
	output logic spi_sck_o,
	output logic spi_si_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		spi_cs_n_o = 1'b1;
		spi_sck_o = 1'b0;
		spi_si_o = 1'b0;
	end

	// Mode 0: data set while sck low, sck idles low between frames
	// Non-blocking so that pin changes landing on a clock edge cannot race the sampler
	task automatic xfer(input logic [39:0] data, input int nbits);
		spi_cs_n_o <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_si_o <= data[39 - i];
			#80 spi_sck_o <= 1'b1;
			#80 spi_sck_o <= 1'b0;
		end
		#80 spi_cs_n_o <= 1'b1;
		// Deselected line must not show a stale bit
		spi_si_o <= ~spi_si_o;
		#80;
	endtask
endmodule

// file: tb/tb_flash_write_protection.sv
// Self-checking bench for the flash write-protection top
module tb_flash_write_protection import fwp_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;

	// ********************************
	// Signals
	// ********************************
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        wp_n_i = 1'b1;
	logic        cs_n, sck, si;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        write_enable_latch, dpd, op_start, op_rej;
	logic [1:0]  drv;
	fwp_op_e     kind;
	logic [23:0] op_addr;
	int          failures = 0;
	int          samples_checked = 0;
	int          n_start = 0;
	int          n_rej = 0;
	// Range table: enable, complement, protect code, low, high
	logic [54:0] rtab [13] = '{
		{2'h0, 5'h00, 48'h0}, {2'h2, 5'h01, 24'hfc0000, 24'hffffff},
		{2'h2, 5'h06, 24'h800000, 24'hffffff}, {2'h2, 5'h09, 24'h0, 24'h03ffff},
		{2'h2, 5'h0e, 24'h0, 24'h7fffff}, {2'h2, 5'h1f, 24'h0, 24'hffffff},
		{2'h2, 5'h11, 24'hfff000, 24'hffffff}, {2'h2, 5'h14, 24'hff8000, 24'hffffff},
		{2'h2, 5'h1e, 24'h0, 24'h007fff}, {2'h3, 5'h01, 24'h0, 24'hfbffff},
		{2'h3, 5'h00, 24'h0, 24'hffffff}, {2'h1, 5'h07, 48'h0},
		{2'h3, 5'h19, 24'h001000, 24'hffffff}};

	always #5 mclk_i = ~mclk_i;

	fwp_spi_host host (.spi_cs_n_o(cs_n), .spi_sck_o(sck), .spi_si_o(si));

	fwp_top DUT (
		.mclk_i               (mclk_i),
		.reset_i              (reset_i),
		.spi_cs_n_i           (cs_n),
		.spi_sck_i            (sck),
		.spi_si_i             (si),
		.wp_n_i               (wp_n_i),
		.reg_addr_i           (reg_addr_i),
		.reg_wdata_i          (reg_wdata_i),
		.reg_wr_i             (reg_wr_i),
		.reg_rd_i             (reg_rd_i),
		.reg_rdata_o          (reg_rdata_o),
		.write_enable_latch_o (write_enable_latch),
		.deep_power_down_o    (dpd),
		.drive_strength_o     (drv),
		.op_start_o           (op_start),
		.op_kind_o            (kind),
		.op_addr_o            (op_addr),
		.op_reject_o          (op_rej)
	);

	always @(posedge mclk_i) begin
		n_start += (op_start === 1'b1);
		n_rej += (op_rej === 1'b1);
	end

	// ********************************
	// Tasks
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o & m, exp & m);
		@(posedge mclk_i);
		#1 check(reg_rdata_o, 32'h0);
	endtask

	// Frame one command, then count launches and refusals it caused
	task automatic spi_cmd(input logic [39:0] d, input int nbits, input int st, input int rj);
		int s0;
		int r0;
		s0 = n_start;
		r0 = n_rej;
		host.xfer(d, nbits);
		repeat (6) @(posedge mclk_i);
		check(n_start - s0, st);
		check(n_rej - r0, rj);
	endtask

	task automatic wren();
		spi_cmd({CMD_WREN, 32'h0}, 8, 0, 0);
	endtask

	task automatic do_reset();
		reset_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic test_done();
		$display("Checks made: %0d, mismatches: %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ********************************
	// Tests
	// ********************************
	initial begin
		// Tests need about 11k cycles; the limit allows over three times that
		#400_000;
		failures++;
		test_done();
	end

	initial begin
		logic [31:0] w;
		do_reset();
		reg_chk(REG_STATUS, 32'h0, '1);
		check(drv, DRV_FULL);
		reg_chk(8'h14, 32'h0, '1);
		reg_wr(REG_NV_IMAGE, 32'h0000_0184);
		reg_chk(REG_STATUS, 32'h0, '1);
		foreach (rtab[i]) begin
			w = 32'h0;
			w[ST_CMP] = rtab[i][53];
			w[6:2] = rtab[i][52:48];
			reg_wr(REG_NV_IMAGE, w);
			reg_chk(REG_STATUS, w, '1);
			reg_chk(REG_PROT_LO, {7'h0, rtab[i][54], rtab[i][47:24]},
				rtab[i][54] ? 32'h01ff_ffff : 32'h0100_0000);
			reg_chk(REG_PROT_HI, {7'h0, rtab[i][54], rtab[i][23:0]},
				rtab[i][54] ? 32'h01ff_ffff : 32'h0100_0000);
		end
		// Top 1/64 protected while commands are gated
		reg_wr(REG_NV_IMAGE, 32'h0000_0004);
		spi_cmd({CMD_SE, 32'h0}, 32, 0, 1);
		wren();
		check(write_enable_latch, 1'b1);
		spi_cmd({CMD_SE, 24'hfc0000, 8'h0}, 32, 0, 1);
		spi_cmd({8'h03, 24'hfc0000, 8'h0}, 32, 0, 0);
		spi_cmd({CMD_CE1, 32'h0}, 8, 0, 1);
		spi_cmd({CMD_SE, 24'hfbf000, 8'h0}, 32, 1, 0);
		check(kind, FWP_OP_SECTOR);
		check(op_addr, 24'hfbf000);
		check(write_enable_latch, 1'b0);
		wren();
		spi_cmd({CMD_PP, 24'hfbfff0, 8'h5a}, 40, 1, 0);
		check(kind, FWP_OP_PROG);
		check(write_enable_latch, 1'b0);
		// Extent reaches into the top 4 kB
		reg_wr(REG_NV_IMAGE, 32'h0000_0044);
		wren();
		spi_cmd({CMD_BE32, 24'hff8000, 8'h0}, 32, 0, 1);
		spi_cmd({CMD_BE64, 24'hfe0000, 8'h0}, 32, 1, 0);
		check(kind, FWP_OP_BLK64);
		reg_wr(REG_NV_IMAGE, 32'h0);
		wren();
		spi_cmd({CMD_CE2, 32'h0}, 8, 1, 0);
		check(kind, FWP_OP_CHIP);
		reg_wr(REG_NV_IMAGE, 32'h0000_401c);
		wren();
		spi_cmd({CMD_CE1, 32'h0}, 8, 1, 0);
		// Status lock modes
		do_reset();
		wren();
		spi_cmd({CMD_WRSR1, 8'h84, 24'h0}, 16, 0, 0);
		reg_chk(REG_STATUS, 32'h84, '1);
		@(posedge mclk_i) wp_n_i <= 1'b0;
		wren();
		spi_cmd({CMD_WRSR1, 8'h00, 24'h0}, 16, 0, 1);
		wp_n_i <= 1'b1;
		spi_cmd({CMD_WRSR2, 8'h01, 24'h0}, 16, 0, 1);
		reg_chk(REG_STATUS, 32'h86, '1);
		spi_cmd({CMD_WRSR1, 8'h04, 24'h0}, 16, 0, 0);
		wren();
		spi_cmd({CMD_WRSR2, 8'h01, 24'h0}, 16, 0, 0);
		reg_chk(REG_STATUS, 32'h104, '1);
		wren();
		spi_cmd({CMD_WRSR1, 8'h00, 24'h0}, 16, 0, 1);
		do_reset();
		reg_chk(REG_STATUS, 32'h0, '1);
		for (int k = 0; k < 4; k++) begin
			wren();
			spi_cmd({CMD_WRSR3, 1'b0, k[1:0], 29'h0}, 16, 0, 0);
			check(drv, k[1:0]);
			check(write_enable_latch, 1'b0);
		end
		reg_chk(REG_STATUS, 32'h0060_0000, '1);
		// Deep power-down and latch clearing
		spi_cmd({CMD_DPD, 32'h0}, 8, 0, 0);
		check(dpd, 1'b1);
		wren();
		spi_cmd({CMD_SE, 32'h0}, 32, 0, 0);
		check(write_enable_latch, 1'b0);
		reg_chk(REG_LAST_OP, 32'h0000_05b9, '1);
		spi_cmd({CMD_RDPD, 32'h0}, 8, 0, 0);
		check(dpd, 1'b0);
		wren();
		spi_cmd({CMD_RSTEN, 32'h0}, 8, 0, 0);
		spi_cmd({CMD_RST, 32'h0}, 8, 0, 0);
		check(write_enable_latch, 1'b0);
		wren();
		spi_cmd({CMD_WRDI, 32'h0}, 8, 0, 0);
		check(write_enable_latch, 1'b0);
		reg_chk(REG_LAST_OP, 32'h0000_0104, '1);
		test_done();
	end
endmodule
